// ### hdl/flash_program_register_interface.sv
// Flash programming register front end: AHB-Lite slave and operation sequencer
`timescale 1ns/100ps
module flash_program_register_interface (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic por_rst,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   output logic flash_req_valid,
   output flash_prog_pkg::flash_req_s flash_req,
   output logic [31:0] row_fetch_addr,
   input wire logic flash_done,
   input wire logic flash_fail,
   input wire logic flash_protected
);

   ////////////////////////////////////////////////////////////////////////////
   // Declarations
   logic por_sync_q1;
   logic por_rst_sync;
   logic done_s;
   logic fail_s;
   logic prot_s;
   logic ap_write;
   logic ap_read;
   logic [7:0] ap_addr;
   logic dp_write;
   logic [7:0] dp_addr;
   logic write_enable;
   logic start;
   logic error_flag;
   logic [3:0] operation_select;
   logic [31:0] flash_target_address;
   logic [31:0] program_data_word;
   logic [31:0] row_source_address;
   logic key_write;
   logic unlocked;
   logic start_set;
   flash_prog_pkg::seq_state_e state;

   // Align a byte address to the unit the operation works on
   function automatic logic [31:0] align_addr(input logic [31:0] a, input int lsb);
      align_addr = (a >> lsb) << lsb;
   endfunction : align_addr

   // Data-phase write aimed at one register offset
   function automatic logic wr_hit(input logic wr, input logic [7:0] a, input logic [7:0] ofs);
      wr_hit = wr && (a == ofs);
   endfunction : wr_hit

   // Control register readback, assembled from the field positions
   function automatic logic [31:0] control_word(input logic go, input logic en, input logic err,
      input logic [3:0] op);
      control_word = 32'h0000_0000;
      control_word[flash_prog_pkg::START_BIT] = go;
      control_word[flash_prog_pkg::ENABLE_BIT] = en;
      control_word[flash_prog_pkg::ERROR_BIT] = err;
      control_word[flash_prog_pkg::OPSEL_LSB +: flash_prog_pkg::OPSEL_W] = op;
   endfunction : control_word

   // Only these four codes reach the array; the rest complete at once as no-ops
   function automatic logic op_is_real(input logic [3:0] op);
      op_is_real = (op == flash_prog_pkg::OP_WORD_PROGRAM)
         || (op == flash_prog_pkg::OP_ROW_PROGRAM)
         || (op == flash_prog_pkg::OP_PAGE_ERASE)
         || (op == flash_prog_pkg::OP_ARRAY_ERASE);
   endfunction : op_is_real

   // Target address cut down to the unit that the chosen operation works on
   function automatic logic [31:0] target_for(input logic [3:0] op, input logic [31:0] a);
      case (op)
         flash_prog_pkg::OP_WORD_PROGRAM: begin
            target_for = align_addr(a, flash_prog_pkg::WORD_LSB);
         end
         flash_prog_pkg::OP_ROW_PROGRAM: begin
            target_for = align_addr(a, flash_prog_pkg::ROW_LSB);
         end
         flash_prog_pkg::OP_PAGE_ERASE: begin
            target_for = align_addr(a, flash_prog_pkg::PAGE_LSB);
         end
         // Whole-array erase does not look at the address at all
         default: target_for = 32'h0000_0000;
      endcase
   endfunction : target_for

   ////////////////////////////////////////////////////////////////////////////
   // Pin inputs are synchronised before use
   input_sync #(.WIDTH(3)) status_sync (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .async_in({flash_done, flash_fail, flash_protected}),
      .sync_out({done_s, fail_s, prot_s})
   );

   // Power-on reset release is brought in with a local synchroniser
   always_ff @(posedge core_clk or posedge por_rst) begin
      if (por_rst) begin
         por_sync_q1 <= 1'b1;
         por_rst_sync <= 1'b1;
      end else begin
         por_sync_q1 <= 1'b0;
         por_rst_sync <= por_sync_q1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // AHB-Lite address phase capture; zero wait states, always OKAY
   assign ap_write = hsel && hready && htrans[1] && hwrite;
   assign ap_read = hsel && hready && htrans[1] && !hwrite;
   assign ap_addr = haddr[7:0];

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         dp_write <= 1'b0;
         dp_addr <= 8'h00;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         dp_write <= ap_write;
         dp_addr <= ap_addr;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
   end

   // Read data is registered at the address phase so it stands in the data phase
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         hrdata <= flash_prog_pkg::RESET_WORD;
      end else if (ap_read) begin
         case (ap_addr)
            flash_prog_pkg::OFS_CONTROL: begin
               hrdata <= control_word(start, write_enable, error_flag, operation_select);
            end
            flash_prog_pkg::OFS_UNLOCK_KEY: hrdata <= 32'h0000_0000;
            flash_prog_pkg::OFS_TARGET_ADDR: hrdata <= flash_target_address;
            flash_prog_pkg::OFS_PROGRAM_DATA: hrdata <= program_data_word;
            flash_prog_pkg::OFS_ROW_SOURCE: hrdata <= row_source_address;
            default: hrdata <= 32'h0000_0000;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Unlock sequence
   assign key_write = wr_hit(dp_write, dp_addr, flash_prog_pkg::OFS_UNLOCK_KEY);
   assign start_set = wr_hit(dp_write, dp_addr, flash_prog_pkg::OFS_CONTROL)
      && hwdata[flash_prog_pkg::START_BIT] && write_enable && unlocked && !start;

   unlock_detect unlock (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .key_write(key_write),
      .key_value(hwdata),
      .consume(dp_write && !key_write),
      .unlocked(unlocked)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Control fields
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         write_enable <= 1'b0;
         operation_select <= flash_prog_pkg::RESET_OPSEL;
      end else if (wr_hit(dp_write, dp_addr, flash_prog_pkg::OFS_CONTROL)) begin
         write_enable <= hwdata[flash_prog_pkg::ENABLE_BIT];
         if (!write_enable) begin
            operation_select <= hwdata[flash_prog_pkg::OPSEL_LSB +: flash_prog_pkg::OPSEL_W];
         end
      end
   end

   // Address registers clear on device reset
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         flash_target_address <= flash_prog_pkg::RESET_WORD;
         row_source_address <= flash_prog_pkg::RESET_WORD;
      end else if (dp_write) begin
         if (dp_addr == flash_prog_pkg::OFS_TARGET_ADDR) begin
            flash_target_address <= hwdata;
         end
         if (dp_addr == flash_prog_pkg::OFS_ROW_SOURCE) begin
            row_source_address <= hwdata;
         end
      end
   end

   // Data word survives device reset; only power-on clears it
   always_ff @(posedge core_clk or posedge por_rst_sync) begin
      if (por_rst_sync) begin
         program_data_word <= flash_prog_pkg::RESET_WORD;
      end else if (wr_hit(dp_write, dp_addr, flash_prog_pkg::OFS_PROGRAM_DATA)) begin
         program_data_word <= hwdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Sequencer state: idle, protection check, request, wait for the array, completion
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         state <= flash_prog_pkg::ST_IDLE;
      end else begin
         case (state)
            flash_prog_pkg::ST_IDLE: begin
               if (start_set) begin
                  state <= flash_prog_pkg::ST_CHECK;
               end
            end
            flash_prog_pkg::ST_CHECK: begin
               // A protected target or a no-op code skips the request but still completes
               if (prot_s || !op_is_real(operation_select)) begin
                  state <= flash_prog_pkg::ST_DONE;
               end else begin
                  state <= flash_prog_pkg::ST_ISSUE;
               end
            end
            flash_prog_pkg::ST_ISSUE: begin
               state <= flash_prog_pkg::ST_WAIT;
            end
            flash_prog_pkg::ST_WAIT: begin
               // No time limit here: an array that never answers keeps the start bit set
               if (fail_s || prot_s || done_s) begin
                  state <= flash_prog_pkg::ST_DONE;
               end
            end
            flash_prog_pkg::ST_DONE: begin
               // Hold until done drops, so the next run cannot take a stale completion
               if (!done_s) begin
                  state <= flash_prog_pkg::ST_IDLE;
               end
            end
            default: state <= flash_prog_pkg::ST_IDLE;
         endcase
      end
   end

   // Start bit: set by an unlocked control write, cleared by hardware on completion
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         start <= 1'b0;
      end else if (state == flash_prog_pkg::ST_IDLE && start_set) begin
         start <= 1'b1;
      end else if (state == flash_prog_pkg::ST_DONE) begin
         start <= 1'b0;
      end
   end

   // Error flag: each run loads it with the protection status at the check; an unprotected no-op run clears it
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         error_flag <= 1'b0;
      end else if (state == flash_prog_pkg::ST_CHECK) begin
         error_flag <= prot_s;
      end else if (state == flash_prog_pkg::ST_WAIT && (fail_s || prot_s)) begin
         error_flag <= 1'b1;
      end
   end

   // Request fields are latched at the check and stand until the next run passes it
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         flash_req <= '0;
         row_fetch_addr <= flash_prog_pkg::RESET_WORD;
      end else if (state == flash_prog_pkg::ST_CHECK && !prot_s) begin
         flash_req.op <= operation_select;
         flash_req.addr <= target_for(operation_select, flash_target_address);
         flash_req.data <= program_data_word;
         row_fetch_addr <= row_source_address;
      end
   end

   // One-cycle request strobe, registered so the array sees a clean edge
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         flash_req_valid <= 1'b0;
      end else begin
         flash_req_valid <= (state == flash_prog_pkg::ST_ISSUE);
      end
   end

endmodule : flash_program_register_interface

// ### include/flash_prog_pkg.sv
// Package: register map, field layout, reset values, opcodes and timing for the flash front end
package flash_prog_pkg;

   // Register byte offsets on the AHB-Lite slave
   localparam logic [7:0] OFS_CONTROL = 8'h00;
   localparam logic [7:0] OFS_UNLOCK_KEY = 8'h04;
   localparam logic [7:0] OFS_TARGET_ADDR = 8'h08;
   localparam logic [7:0] OFS_PROGRAM_DATA = 8'h0c;
   localparam logic [7:0] OFS_ROW_SOURCE = 8'h10;

   // Control register field positions
   localparam int START_BIT = 15;
   localparam int ENABLE_BIT = 14;
   localparam int ERROR_BIT = 13;
   localparam int OPSEL_LSB = 0;
   localparam int OPSEL_W = 4;

   // Reset values
   localparam logic [31:0] RESET_WORD = 32'h0000_0000;
   localparam logic [3:0] RESET_OPSEL = 4'h0;

   // Unlock key pair, written in this order
   localparam logic [31:0] KEY_FIRST = 32'haa99_6655;
   localparam logic [31:0] KEY_SECOND = 32'h5566_99aa;

   // Operation codes
   localparam logic [3:0] OP_WORD_PROGRAM = 4'h1;
   localparam logic [3:0] OP_ROW_PROGRAM = 4'h3;
   localparam logic [3:0] OP_PAGE_ERASE = 4'h4;
   localparam logic [3:0] OP_ARRAY_ERASE = 4'h5;

   // Geometry: page 1 KB, row 128 bytes
   localparam int PAGE_LSB = 10;
   localparam int ROW_LSB = 7;
   localparam int WORD_LSB = 2;
   localparam logic [7:0] ROW_WORDS = 8'h20;

   // Timing
   localparam int CLK_PERIOD_NS = 8;
   localparam int UNLOCK_WINDOW_NS = 64;
   localparam int UNLOCK_WINDOW_CYC = (UNLOCK_WINDOW_NS / CLK_PERIOD_NS < 1) ? 1 :
      UNLOCK_WINDOW_NS / CLK_PERIOD_NS;

   // Request to the flash array
   typedef struct packed {
      logic [3:0] op;
      logic [31:0] addr;
      logic [31:0] data;
   } flash_req_s;

   // Macro state
   typedef enum logic [2:0] {ST_IDLE, ST_CHECK, ST_ISSUE, ST_WAIT, ST_DONE} seq_state_e;

endpackage : flash_prog_pkg

// ### hdl/input_sync.sv
// Two flip-flop synchroniser for level inputs from outside the clock domain
`timescale 1ns/100ps
module input_sync #(
   parameter int WIDTH = 1
) (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta;

   // First stage only feeds the second
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         meta <= '0;
         sync_out <= '0;
      end else begin
         meta <= async_in;
         sync_out <= meta;
      end
   end
endmodule : input_sync

// ### hdl/unlock_detect.sv
// Unlock sequence detector: two key writes back to back arm the start bit briefly
`timescale 1ns/100ps
module unlock_detect (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic key_write,
   input wire logic [31:0] key_value,
   input wire logic consume,
   output logic unlocked
);
   logic first_seen;
   logic [7:0] window;

   // First key opens a short window; the second must land inside it
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         first_seen <= 1'b0;
         unlocked <= 1'b0;
         window <= 8'h00;
      end else if (key_write) begin
         first_seen <= (key_value == flash_prog_pkg::KEY_FIRST);
         unlocked <= first_seen && (key_value == flash_prog_pkg::KEY_SECOND);
         window <= 8'(flash_prog_pkg::UNLOCK_WINDOW_CYC);
      end else if (consume || window == 8'h00) begin
         // Any other bus write ends the window, so a stray write cannot reuse it
         first_seen <= 1'b0;
         unlocked <= 1'b0;
      end else begin
         window <= window - 8'h01;
      end
   end
endmodule : unlock_detect

// ### sim/flash_prog_asserts.sv
// Checker: key readback and request shape at the flash side
`timescale 1ns/100ps
module flash_prog_checker (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   input wire logic flash_req_valid,
   input wire flash_prog_pkg::flash_req_s flash_req
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (sys_rst);
   // Read address phase aimed at the key register
   wire logic key_rd = hsel && hready && htrans[1] && !hwrite &&
      haddr[7:0] == flash_prog_pkg::OFS_UNLOCK_KEY;
   wire logic [3:0] op = flash_req.op;
   wire logic [31:0] fa = flash_req.addr;
   property p_key_zero; key_rd |=> hrdata == 32'h0000_0000; endproperty
   a_key_zero: assert property (p_key_zero) else $error("key read not zero");
   property p_array_addr;
      flash_req_valid && op == flash_prog_pkg::OP_ARRAY_ERASE |-> fa == 32'h0000_0000;
   endproperty
   a_array_addr: assert property (p_array_addr) else $error("array erase addr");
   property p_page_addr;
      flash_req_valid && op == flash_prog_pkg::OP_PAGE_ERASE |-> fa[9:0] == 10'h000;
   endproperty
   a_page_addr: assert property (p_page_addr) else $error("page addr");
   property p_row_addr;
      flash_req_valid && op == flash_prog_pkg::OP_ROW_PROGRAM |-> fa[6:0] == 7'h00;
   endproperty
   a_row_addr: assert property (p_row_addr) else $error("row addr");
   property p_word_addr;
      flash_req_valid && op == flash_prog_pkg::OP_WORD_PROGRAM |-> fa[1:0] == 2'h0;
   endproperty
   a_word_addr: assert property (p_word_addr) else $error("word addr");
   property p_pulse; flash_req_valid |=> !flash_req_valid; endproperty
   a_pulse: assert property (p_pulse) else $error("request not a pulse");
   property p_req_hold; flash_req_valid |=> $stable(flash_req) [*3]; endproperty
   a_req_hold: assert property (p_req_hold) else $error("request moved");
   property p_op_code; flash_req_valid |-> op inside {4'h1, 4'h3, 4'h4, 4'h5}; endproperty
   a_op_code: assert property (p_op_code) else $error("bad op issued");
   // Main scenarios reached
   c_key: cover property (key_rd);
   c_word: cover property (flash_req_valid && op == flash_prog_pkg::OP_WORD_PROGRAM);
   c_array: cover property (flash_req_valid && op == flash_prog_pkg::OP_ARRAY_ERASE);
endmodule : flash_prog_checker
bind flash_program_register_interface flash_prog_checker i_chk (.core_clk, .sys_rst, .hsel,
   .haddr, .htrans, .hwrite, .hready, .hrdata, .flash_req_valid, .flash_req);

// ### sim/flash_array_model.sv
// Behavioural flash array: answers promptly or slowly, can report protection or failure
`timescale 1ns/100ps
module flash_array_model (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic flash_req_valid,
   input wire logic protect_on,
   input wire logic fail_on,
   input wire logic slow,
   output logic flash_done,
   output logic flash_fail,
   output logic flash_protected
);
   logic [7:0] cnt;
   // Busy countdown; the answer stands five cycles so the synchroniser sees it
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) cnt <= 8'h00;
      else if (flash_req_valid) cnt <= slow ? 8'h30 : 8'h08;
      else if (cnt != 8'h00) cnt <= cnt - 8'h01;
   end
   // Completion or failure during the last steps of the countdown
   assign flash_done = cnt != 8'h00 && cnt < 8'h06 && !fail_on;
   assign flash_fail = cnt != 8'h00 && cnt < 8'h06 && fail_on;
   assign flash_protected = protect_on;
endmodule : flash_array_model

// ### sim/flash_program_register_interface_tb.sv
// Testbench: registers, unlock, operations, refusals and the two resets
`timescale 1ns/100ps
module flash_program_register_interface_tb;
   localparam logic [7:0] CT = flash_prog_pkg::OFS_CONTROL, KY = flash_prog_pkg::OFS_UNLOCK_KEY;
   localparam logic [7:0] TA = flash_prog_pkg::OFS_TARGET_ADDR, RS = flash_prog_pkg::OFS_ROW_SOURCE;
   localparam logic [7:0] PD = flash_prog_pkg::OFS_PROGRAM_DATA;
   localparam logic [31:0] ST = 32'h1 << flash_prog_pkg::START_BIT;
   localparam logic [31:0] EN = 32'h1 << flash_prog_pkg::ENABLE_BIT;
   localparam logic [31:0] ERR = 32'h1 << flash_prog_pkg::ERROR_BIT;
   localparam logic [3:0] WP = flash_prog_pkg::OP_WORD_PROGRAM, RP = flash_prog_pkg::OP_ROW_PROGRAM;
   localparam logic [3:0] PE = flash_prog_pkg::OP_PAGE_ERASE, AE = flash_prog_pkg::OP_ARRAY_ERASE;
   logic core_clk = 0, sys_rst = 1, por_rst = 1, hsel = 0, hwrite = 0;
   logic [31:0] haddr = 0, hwdata = 0, hrdata, row_fetch_addr, rd;
   logic [1:0] htrans = 0;
   logic [2:0] hsize = 3'h2;
   logic hreadyout, hresp, flash_req_valid, flash_done, flash_fail, flash_protected;
   logic protect_on = 0, fail_on = 0, slow = 0;
   flash_prog_pkg::flash_req_s flash_req, cap;
   int error_cnt = 0, comparisons = 0, seen = 0;
   always #4 core_clk = ~core_clk;
   flash_program_register_interface i_dut (.core_clk, .sys_rst, .por_rst, .hsel, .haddr, .htrans,
      .hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .flash_req_valid,
      .flash_req, .row_fetch_addr, .flash_done, .flash_fail, .flash_protected);
   flash_array_model i_flash (.core_clk, .sys_rst, .flash_req_valid, .protect_on, .fail_on, .slow,
      .flash_done, .flash_fail, .flash_protected);
   // Record each request pulse the sequencer issues
   always @(posedge core_clk) if (flash_req_valid === 1'b1) begin
      seen++;
      cap = flash_req;
   end
   ////////////////////////////////////////////////////////////////
   task automatic print_verdict;
      $display("errors %0d comparisons %0d", error_cnt, comparisons);
      if (error_cnt == 0 && comparisons > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : print_verdict
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         error_cnt++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // Bounded wait for hready; a hang ends the run
   task automatic wait_rdy;
      int n;
      n = 0;
      do begin
         @(posedge core_clk);
         n++;
      end while (hreadyout !== 1'b1 && n < 20);
      if (hreadyout !== 1'b1) begin
         error_cnt++;
         print_verdict;
      end
   endtask : wait_rdy
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      haddr <= {24'h0, a}; hwrite <= w; htrans <= 2'h2; hsel <= 1'b1;
      wait_rdy;
      htrans <= 2'h0; hwdata <= d;
      wait_rdy;
      rd = hrdata;
      // The slave must answer OKAY on every transfer
      chk({31'h0, hresp}, 32'h0000_0000);
   endtask : bus
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk(rd, e);
   endtask : rd_chk
   // Old enable gates op select, so clear enable first, then op, enable, keys, start
   task automatic launch(input logic [3:0] op);
      logic [31:0] o;
      o = {28'h0, op};
      bus(1, CT, 0); bus(1, CT, o); bus(1, CT, EN | o);
      bus(1, KY, flash_prog_pkg::KEY_FIRST); bus(1, KY, flash_prog_pkg::KEY_SECOND);
      bus(1, CT, ST | EN | o);
   endtask : launch
   task automatic finish_op(input logic [31:0] err);
      int n;
      n = 0;
      do begin bus(0, CT, 0); n++; end while (rd[15] !== 1'b0 && n < 100);
      chk(rd & (ST | ERR), err);
      if (rd[15] !== 1'b0) begin
         error_cnt++;
         print_verdict;
      end
   endtask : finish_op
   ////////////////////////////////////////////////////////////////
   task automatic t_regs;
      rd_chk(CT, 0); rd_chk(TA, 0); rd_chk(PD, 0); rd_chk(RS, 0);
      bus(1, TA, 32'h0000_1ff7); bus(1, PD, 32'hdead_beef); bus(1, RS, 32'h0000_4000);
      bus(1, KY, 32'h1234_5678); bus(1, 8'h14, 32'hffff_ffff);
      rd_chk(TA, 32'h0000_1ff7);
      rd_chk(PD, 32'hdead_beef);
      rd_chk(RS, 32'h0000_4000);
      rd_chk(KY, 0);
      rd_chk(8'h14, 0);
   endtask : t_regs
   task automatic t_faults;
      int n0;
      n0 = seen;
      protect_on <= 1'b1;
      launch(PE); finish_op(ERR);
      chk(seen, n0);
      protect_on <= 1'b0; fail_on <= 1'b1;
      launch(WP); finish_op(ERR);
      fail_on <= 1'b0;
      // A no-op code completes without a request and clears the error left above
      n0 = seen;
      launch(4'h0);
      finish_op(32'h0000_0000);
      chk(seen, n0);
   endtask : t_faults
   task automatic t_ops;
      logic [3:0] ops [4];
      logic [31:0] msk [4];
      int n0;
      ops = '{WP, RP, PE, AE};
      msk = '{32'hffff_fffc, 32'hffff_ff80, 32'hffff_fc00, 32'h0};
      for (int i = 0; i < 4; i++) begin
         n0 = seen;
         slow <= i[0];
         launch(ops[i]); finish_op(0);
         chk(seen, n0 + 1);
         chk(cap.op, ops[i]);
         chk(cap.addr, 32'h0000_1ff7 & msk[i]);
         if (i == 0) chk(cap.data, 32'hdead_beef);
         if (i == 1) chk(row_fetch_addr, 32'h0000_4000);
      end
   endtask : t_ops
   task automatic t_refuse;
      int n0;
      bus(1, CT, 0); bus(1, CT, WP); bus(1, CT, EN | WP); bus(1, CT, EN | PE);
      rd_chk(CT, EN | WP);
      n0 = seen;
      bus(1, CT, ST | EN | WP);
      repeat (20) @(posedge core_clk);
      rd_chk(CT, EN | WP);
      chk(seen, n0);
   endtask : t_refuse
   task automatic t_por;
      bus(1, PD, 32'h0bad_cafe); bus(1, TA, 32'h0000_0055);
      sys_rst <= 1'b1; repeat (2) @(posedge core_clk); sys_rst <= 1'b0; @(posedge core_clk);
      rd_chk(PD, 32'h0bad_cafe);
      rd_chk(TA, 0);
      por_rst <= 1'b1; repeat (2) @(posedge core_clk); por_rst <= 1'b0;
      repeat (3) @(posedge core_clk);
      rd_chk(PD, 0);
   endtask : t_por
   // Main sequence
   initial begin
      repeat (20) @(posedge core_clk);
      sys_rst <= 1'b0; por_rst <= 1'b0;
      @(posedge core_clk);
      t_regs; t_faults; t_ops; t_refuse; t_por;
      print_verdict;
   end
endmodule : flash_program_register_interface_tb
